/* File: logic/strap_pkg.sv */
// strap sampler constants: timing, reset values, register map
// assumes a 20 MHz pclk and an apb master of 32-bit data
package strap_pkg;
  localparam int unsigned clk_hz = 20000000;
  // capture delay after reset release, in microseconds
  localparam int unsigned capture_delay_us = 2000;
  localparam int unsigned capture_delay_cycles = capture_delay_us * (clk_hz / 1000000);
  // internal reset hold, longest figure, in milliseconds
  localparam int unsigned por_hold_ms = 110;
  localparam int unsigned por_hold_cycles = por_hold_ms * (clk_hz / 1000);
  // register byte offsets
  localparam logic [11:0] cfg_off = 12'h000;
  localparam logic [11:0] status_off = 12'h004;
  localparam logic [11:0] raw_off = 12'h008;
  localparam logic [11:0] ctrl_off = 12'h00c;
  // field positions in cfg and raw
  localparam int unsigned host_if_pos = 0;
  localparam int unsigned wcore_boot_pos = 1;
  localparam int unsigned acore_boot_pos = 2;
  localparam int unsigned card_role_pos = 3;
  localparam int unsigned voltage_trim_pos = 4;
  localparam int unsigned dbg_clk_pos = 5;
  localparam int unsigned init_mode_pos = 6;
  localparam int unsigned osc_src_pos = 7;
  localparam int unsigned usb_role_pos = 8;
  localparam int unsigned strap_bits = 9;
  // chip default levels, usb role defaults to device (high)
  localparam logic [8:0] strap_reset = 9'h100;
  // synchroniser reset: wake input idles high
  localparam logic [12:0] sync_reset = 13'h0800;
  // decoded modes for the reset straps
  localparam logic [8:0] mode_reset = 9'h101;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  typedef enum logic [1:0] {st_hold, st_wait, st_done} state_e;
endpackage : strap_pkg

/* File: logic/power_on_strap_sampler.sv */
// power-on strap sampler with apb status registers
// assumes pins are asynchronous to pclk; presetn is the external reset
`timescale 1ns/1ps

module power_on_strap_sampler #(
  parameter int unsigned capture_cycles = strap_pkg::capture_delay_cycles,
  parameter int unsigned por_cycles = strap_pkg::por_hold_cycles,
  parameter bit rev_b0 = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins, asynchronous
  input wire logic [8:0] strap_pins,
  input wire logic crystal_present,
  input wire logic hibernate_osc_select,
  input wire logic hibernate_regulator_enable_in,
  input wire logic hibernate_wake_input_n,
  // pin ownership and decoded modes
  output logic straps_active,
  output logic core_reset_n,
  output logic slave_serial_interface_en,
  output logic wireless_core_boot_sram,
  output logic application_core_boot_sram,
  output logic card_host_role,
  output logic voltage_trim_en,
  output logic debug_clock_from_crystal,
  output logic power_init_mode1,
  output logic lowpower_osc_internal,
  output logic hibernate_osc_use_crystal,
  output logic usb_device_role,
  output logic hibernate_regulator_enable_out,
  output logic wake_request
);

  // two-flop synchronisers; only the second stage feeds logic
  localparam int unsigned sync_w = 13;
  logic [sync_w-1:0] pins_raw;
  logic [sync_w-1:0] pins_m_q;
  logic [sync_w-1:0] pins_s_q;

  assign pins_raw = {hibernate_osc_select, hibernate_wake_input_n,
                     hibernate_regulator_enable_in, crystal_present, strap_pins};

  // wake stage resets high, its idle level, so reset raises no wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_m_q <= strap_pkg::sync_reset;
      pins_s_q <= strap_pkg::sync_reset;
    end else begin
      pins_m_q <= pins_raw;
      pins_s_q <= pins_m_q;
    end
  end

  wire [8:0] strap_sync = pins_s_q[8:0];
  wire crystal_sync = pins_s_q[9];
  wire reg_en_sync = pins_s_q[10];
  wire wake_n_sync = pins_s_q[11];
  wire osc_sel_sync = pins_s_q[12];

  // strap levels to mode enables, one bit per strap field
  function automatic logic [8:0] decode_straps(input logic [8:0] s);
    logic [8:0] m;
    m = s;

    // host interface enabled by a low strap
    m[strap_pkg::host_if_pos] = ~s[strap_pkg::host_if_pos];
    // trim strap is no strap on b0
    if (rev_b0) begin
      m[strap_pkg::voltage_trim_pos] = 1'b0;
    end
    return m;
  endfunction : decode_straps

  // last cycle of a counted phase
  function automatic logic limit_reached(input logic [31:0] cnt, input int unsigned limit);
    return (cnt >= limit - 1);
  endfunction : limit_reached

  // one aligned register word
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    return (addr == off);
  endfunction : reg_hit

  // status word: state, done, conflict, crystal, regulator, wake
  function automatic logic [31:0] status_word(input strap_pkg::state_e st,
                                              input logic conflict, input logic use_xtal,
                                              input logic reg_on, input logic wake);
    return {25'h0000000, wake, reg_on, use_xtal, conflict, st == strap_pkg::st_done, st};
  endfunction : status_word

  // raw word: synchronised pin levels as they stand
  function automatic logic [31:0] raw_word(input logic [11:0] pins);
    return {20'h00000, pins};
  endfunction : raw_word

  // ctrl word: bit 0 is a strobe and reads back zero
  function automatic logic [31:0] ctrl_word(input logic [31:0] wdata);
    return {wdata[31:1], 1'b0};
  endfunction : ctrl_word

  // reset hold and capture sequencing
  // counts fit 32 bits for the longest hold
  strap_pkg::state_e state_q;
  strap_pkg::state_e state_d;
  logic [31:0] count_q;
  logic [31:0] count_d;

  logic [8:0] strap_q;
  logic [8:0] mode_q;
  logic hib_sel_q;
  logic conflict_q;
  logic use_xtal_q;

  logic [31:0] ctrl_q;
  logic soft_recapture;

  wire hold_done = limit_reached(count_q, por_cycles);
  wire wait_done = limit_reached(count_q, capture_cycles);

  always_comb begin
    state_d = state_q;
    case (state_q)
      strap_pkg::st_hold: begin
        if (hold_done) begin
          state_d = strap_pkg::st_wait;
        end
      end
      strap_pkg::st_wait: begin
        if (wait_done) begin
          state_d = strap_pkg::st_done;
        end
      end
      strap_pkg::st_done: begin
        if (soft_recapture) begin
          state_d = strap_pkg::st_wait;
        end
      end
      default: begin
        state_d = strap_pkg::st_hold;
      end
    endcase
  end

  // phase counter restarts whenever the state moves on
  always_comb begin
    count_d = count_q + 32'h1;
    case (state_q)
      strap_pkg::st_hold: begin
        if (hold_done) begin
          count_d = 32'h0;
        end
      end
      strap_pkg::st_wait: begin
        if (wait_done) begin
          count_d = 32'h0;
        end
      end
      strap_pkg::st_done: begin
        count_d = 32'h0;
      end
      default: begin
        count_d = 32'h0;
      end
    endcase
  end

  wire capture_now = (state_q == strap_pkg::st_wait) && wait_done;

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= strap_pkg::st_hold;
    end else begin
      state_q <= state_d;
    end
  end

  // phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 32'h0;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q <= strap_pkg::strap_reset;
      hib_sel_q <= 1'b0;
    end else if (capture_now) begin
      strap_q <= strap_sync;
      hib_sel_q <= osc_sel_sync;
    end
  end

  // decoded modes in flops of their own, loaded with the straps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= strap_pkg::mode_reset;
      conflict_q <= 1'b0;
    end else if (capture_now) begin
      mode_q <= decode_straps(strap_sync);
      // host interface and card host both set
      conflict_q <= ~strap_sync[strap_pkg::host_if_pos] & strap_sync[strap_pkg::card_role_pos];
    end
  end

  // crystal unless select latched high; select taken at capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_xtal_q <= 1'b0;
    end else begin
      use_xtal_q <= crystal_sync & ~(capture_now ? osc_sel_sync : hib_sel_q);
    end
  end

  assign straps_active = (state_q != strap_pkg::st_done);
  assign core_reset_n = (state_q == strap_pkg::st_done);

  assign slave_serial_interface_en = mode_q[strap_pkg::host_if_pos];

  assign wireless_core_boot_sram = mode_q[strap_pkg::wcore_boot_pos];

  assign application_core_boot_sram = mode_q[strap_pkg::acore_boot_pos];

  assign card_host_role = mode_q[strap_pkg::card_role_pos];

  // trim, not a strap on b0
  assign voltage_trim_en = mode_q[strap_pkg::voltage_trim_pos];

  assign debug_clock_from_crystal = mode_q[strap_pkg::dbg_clk_pos];

  assign power_init_mode1 = mode_q[strap_pkg::init_mode_pos];

  assign lowpower_osc_internal = mode_q[strap_pkg::osc_src_pos];

  assign usb_device_role = mode_q[strap_pkg::usb_role_pos];

  // auto pick, strap only with crystal
  assign hibernate_osc_use_crystal = use_xtal_q;

  assign hibernate_regulator_enable_out = reg_en_sync;

  assign wake_request = ~wake_n_sync;

  // apb slave, zero wait states
  wire setup_ok = psel & ~penable;
  wire access = psel & penable;
  wire hit_cfg = reg_hit(paddr, strap_pkg::cfg_off);
  wire hit_status = reg_hit(paddr, strap_pkg::status_off);
  wire hit_raw = reg_hit(paddr, strap_pkg::raw_off);
  wire hit_ctrl = reg_hit(paddr, strap_pkg::ctrl_off);

  wire mapped = hit_cfg | hit_status | hit_raw | hit_ctrl;
  wire wr_ctrl = access & pwrite & hit_ctrl;

  // write of bit 0 in ctrl re-runs capture; pins go back to strap duty
  assign soft_recapture = wr_ctrl & pwdata[0];

  // read selection; unmapped words read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg) begin
      rd_mux = {23'h000000, strap_q};
    end else if (hit_status) begin
      rd_mux = status_word(state_q, conflict_q, use_xtal_q, reg_en_sync, wake_request);
    end else if (hit_raw) begin
      rd_mux = raw_word(pins_s_q[11:0]);
    end else if (hit_ctrl) begin
      rd_mux = ctrl_q;
    end
  end

  // read data loaded in setup, so it stands at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ok && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ctrl scratch bits; writes elsewhere change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= strap_pkg::ctrl_reset;
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_word(pwdata);
    end
  end

  // unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

endmodule : power_on_strap_sampler

/* File: dv/strap_board.sv */
// board strap pulls and supply sequencing model
// assumes supplies are good from time zero
`timescale 1ns/1ps
module strap_board (
  // clock and requested pulls
  input wire logic pclk,
  input wire logic [8:0] pull_level,
  // pins
  output logic [8:0] strap_pins,
  output logic hibernate_regulator_enable_in
);
  logic [11:0] up_q = 12'h000;
  // card host only without host interface
  assign strap_pins = {pull_level[8:4], pull_level[3] & pull_level[0], pull_level[2:0]};
  // enable low past two reference periods
  assign hibernate_regulator_enable_in = up_q[11];
  always_ff @(posedge pclk) begin
    if (!up_q[11]) begin
      up_q <= up_q + 12'h001;
    end
  end
endmodule : strap_board

/* File: dv/power_on_strap_sampler_chk.sv */
// port checks for the strap sampler
// assumes counts of 16 hold and 8 wait cycles
`timescale 1ns/1ps
module power_on_strap_sampler_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // hibernation and modes
  input wire logic hibernate_regulator_enable_in,
  input wire logic hibernate_regulator_enable_out,
  input wire logic hibernate_wake_input_n,
  input wire logic wake_request,
  input wire logic straps_active,
  input wire logic core_reset_n,
  input wire logic usb_device_role
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_release;
    $rose(presetn);
  endsequence
  sequence s_settled;
    !straps_active ##1 !straps_active;
  endsequence
  a_reset_pair: assert property (core_reset_n == !straps_active)
    else $error("core reset and pin ownership disagree");
  a_capture_late: assert property (s_release |-> straps_active [*8])
    else $error("capture too early");
  a_capture_bound: assert property (s_release |-> ##[1:40] !straps_active)
    else $error("capture too late");
  a_modes_held: assert property (s_settled |-> $stable(usb_device_role))
    else $error("mode changed after capture");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("no ready");
  a_bad_addr: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
    else $error("unmapped access accepted");
  a_reg_follow: assert property ($rose(hibernate_regulator_enable_in)
    |-> ##[1:3] hibernate_regulator_enable_out)
    else $error("regulators not enabled");
  a_wake_map: assert property (!hibernate_wake_input_n [*3] |-> wake_request)
    else $error("wake not seen");
endmodule : power_on_strap_sampler_chk

/* File: dv/power_on_strap_sampler_tb_top.sv */
// self-checking bench for the strap sampler
// assumes the board model and checker beside it
`timescale 1ns/1ps
module power_on_strap_sampler_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, lfsr = 32'h0000_596f;
  logic pready, pslverr, err, act, core_n, reg_in, reg_out, wake_req;
  logic crystal = 1'b0;
  logic osc_sel = 1'b0;
  logic wake_n = 1'b1;
  logic [8:0] pull = 9'h100;
  logic [8:0] pins;
  logic [9:0] modes;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 pclk = ~pclk;
  strap_board u_board (.pclk(pclk), .pull_level(pull), .strap_pins(pins),
    .hibernate_regulator_enable_in(reg_in));
  power_on_strap_sampler #(.capture_cycles(8), .por_cycles(16)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_pins(pins),
    .crystal_present(crystal), .hibernate_osc_select(osc_sel),
    .hibernate_regulator_enable_in(reg_in), .hibernate_wake_input_n(wake_n),
    .straps_active(act), .core_reset_n(core_n), .slave_serial_interface_en(modes[9]),
    .wireless_core_boot_sram(modes[8]), .application_core_boot_sram(modes[7]),
    .card_host_role(modes[6]), .voltage_trim_en(modes[5]),
    .debug_clock_from_crystal(modes[4]), .power_init_mode1(modes[3]),
    .lowpower_osc_internal(modes[2]), .usb_device_role(modes[1]),
    .hibernate_osc_use_crystal(modes[0]), .hibernate_regulator_enable_out(reg_out),
    .wake_request(wake_req));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [8:0] board(input logic [8:0] p);
    return {p[8:4], p[3] & p[0], p[2:0]};
  endfunction : board
  function automatic logic [9:0] expect_modes(input logic [8:0] p, input logic x, s);
    logic [8:0] b;
    b = board(p);
    return {~b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7], b[8], x & ~s};
  endfunction : expect_modes
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_cap(input int min_n);
    int n;
    n = 0;
    @(posedge pclk);
    while (act !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n >= min_n), 32'h1);
    check(32'(modes), 32'(expect_modes(pull, crystal, osc_sel)));
  endtask : wait_cap
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      presetn <= 1'b0;
      pull <= (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : lfsr[8:0];
      crystal <= lfsr[9];
      osc_sel <= lfsr[10];
      @(posedge pclk);
      check(32'(modes[9:1]), 32'h101);
      check(32'(reg_out), 32'h0);
      presetn <= 1'b1;
      wait_cap(20);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'(board(pull)));
      apb(1'b0, 12'h004, 32'h0);
      check(rd, {27'h0000000, crystal & ~osc_sel, 4'h6});
      apb(1'b0, 12'h008, 32'h0);
      check(rd, {20'h00000, wake_n, 1'b0, crystal, board(pull)});
      pull <= ~pull;
      repeat (4) @(posedge pclk);
      check(32'(modes), 32'(expect_modes(~pull, crystal, osc_sel)));
    end
    apb(1'b0, 12'h010, 32'h0);
    check({rd[31:1], err}, 32'h1);
    apb(1'b1, 12'h00c, 32'haaaa_aaaa);
    apb(1'b0, 12'h00c, 32'h0);
    check(rd, 32'haaaa_aaaa);
    pull <= 9'h0a5;
    apb(1'b1, 12'h00c, 32'h0000_0001);
    wait_cap(6);
    wake_n <= 1'b0;
    repeat (4) @(posedge pclk);
    check(32'(wake_req), 32'h1);
    repeat (2100) @(posedge pclk);
    check(32'(reg_out), 32'h1);
    conclude();
  end
endmodule : power_on_strap_sampler_tb_top
bind power_on_strap_sampler power_on_strap_sampler_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .hibernate_regulator_enable_in(hibernate_regulator_enable_in),
  .hibernate_regulator_enable_out(hibernate_regulator_enable_out),
  .hibernate_wake_input_n(hibernate_wake_input_n), .wake_request(wake_request),
  .straps_active(straps_active), .core_reset_n(core_reset_n),
  .usb_device_role(usb_device_role));
